// [core/aeqc_defs.svh]
// Purpose: constants for the adaptive equalizer control block
// Assumes: 200 MHz core clock, 25 MHz reference time base
// Notes:   offsets, fields, reset values and timing counts
//
// Behaviour
// - restart bit restarts adaption at any time
// - search steps continuously from power-on until lock
// - restart once on first lock, can be disabled
// - restart or soft reset begins from start gain
// - gain never stepped above programmed ceiling
// - floor field gives start and lowest gain
// - floor limit applies only when floor enabled
// - current gain setting readable in status register
// - wait dwell interval before advancing gain
// - reset dwell select gives about 2.62 ms
// - no lock at ceiling wraps to low limit
// - error sources individually selectable, checking default on
// - errors counted over half dwell interval
// - error count above limit advances gain
// - hold gain while lock persists and error count stays within limit
// - lock loss advances to next valid gain
`ifndef AEQC_DEFS_SVH
`define AEQC_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define AEQC_OFS_ERR_SEL     8'h42
`define AEQC_OFS_CTRL        8'hd2
`define AEQC_OFS_STATUS      8'hd3
`define AEQC_OFS_RANGE       8'hd5

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define AEQC_ES_CDR_BIT      0
`define AEQC_ES_ENC_BIT      1
`define AEQC_ES_PAR_BIT      2
`define AEQC_ES_CHK_BIT      3
`define AEQC_ES_LIM_LSB      4
`define AEQC_CT_FLOOR_EN_BIT 2
`define AEQC_CT_RESTART_BIT  3
`define AEQC_CT_FIRST_BIT    4
`define AEQC_CT_DWELL_LSB    5
`define AEQC_ST_HOLD_BIT     4
`define AEQC_RG_CEIL_LSB     4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AEQC_ERR_SEL_RST     8'h1f
`define AEQC_CTRL_RST        8'h70
`define AEQC_RANGE_RST       8'hf0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AEQC_CLK_PERIOD_PS   5000
`define AEQC_REF_PERIOD_PS   40000
`define AEQC_REF_DIV         (`AEQC_REF_PERIOD_PS / `AEQC_CLK_PERIOD_PS)
`define AEQC_DWELL_RST_NS    2620000
`define AEQC_DWELL_RST_SEL   3
// unit ticks for the reset select, rounded up, never short
// ns over ns keeps the sum inside 32 bits
`define AEQC_DWELL_UNIT_TICKS \
	((`AEQC_DWELL_RST_NS / (`AEQC_REF_PERIOD_PS / 1000) \
	  + (1 << `AEQC_DWELL_RST_SEL) - 1) >> `AEQC_DWELL_RST_SEL)

`endif

// [core/aeqc_pkg.sv]
// Purpose: shared types of the adaptive equalizer control block
// Assumes: constants live in aeqc_defs.svh
// Notes:   one-hot search state
package aeqc_pkg;

	// ----------------------------------------------------------------
	// search state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		AEQC_SEARCH = 2'b01,      // stepping through gain values
		AEQC_HOLD   = 2'b10       // settled, watching lock and errors
	} aeqc_state_t;

	typedef logic [3:0] aeqc_gain_t;   // equalizer gain code

endpackage : aeqc_pkg

// [core/aeqc_timebase.sv]
// Purpose: reference tick divider and dwell interval timer
// Assumes: clear is a one-cycle pulse from the search logic
// Notes:   dwell length is unit ticks shifted by select
`timescale 1ns/1ps
`include "aeqc_defs.svh"

module aeqc_timebase #(
	parameter int DWELL_UNIT_TICKS = `AEQC_DWELL_UNIT_TICKS
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       clear,
	input  wire logic [2:0] select,
	output logic            in_window,
	output logic            half_end,
	output logic            dwell_end
);

	localparam logic [2:0] REF_LAST = 3'(`AEQC_REF_DIV - 1);

	logic [2:0]  ref_cnt;          // core cycles per reference tick
	logic [23:0] dwell_cnt;        // reference ticks into this dwell
	logic        ref_tick;         // one-cycle 25 MHz enable
	logic [23:0] dwell_len;        // ticks in a full dwell
	logic [23:0] half_len;         // ticks in the error window

	assign ref_tick  = (ref_cnt == REF_LAST);
	assign dwell_len = 24'(DWELL_UNIT_TICKS) << select;
	assign half_len  = dwell_len >> 1;
	assign in_window = (dwell_cnt < half_len);
	// no clear term: clear is built from these strobes, a loop otherwise
	assign half_end  = ref_tick
	                   && (dwell_cnt == half_len - 24'h1);
	assign dwell_end = ref_tick
	                   && (dwell_cnt == dwell_len - 24'h1);

	// ----------------------------------------------------------------
	// divider and dwell counter
	// ----------------------------------------------------------------
	// clear restarts the divider too, so every window is equal length
	always_ff @(posedge clk) begin
		if (reset || clear) begin
			ref_cnt   <= 3'h0;
			dwell_cnt <= 24'h0;
		end else if (ref_tick) begin
			ref_cnt   <= 3'h0;
			dwell_cnt <= dwell_end ? 24'h0 : dwell_cnt + 24'h1;
		end else begin
			ref_cnt   <= ref_cnt + 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_TIMER_CLEAR: assert property (
		@(posedge clk) disable iff (reset)
		clear |=> (dwell_cnt == 24'h0) && (ref_cnt == 3'h0))
		else $error("dwell timer not cleared");

endmodule : aeqc_timebase

// [core/aeqc_top.sv]
// Purpose: adaptive equalizer gain search and its registers
// Assumes: lock and error inputs come from another clock domain
// Notes:   gain_code drives the analog equalizer directly
`timescale 1ns/1ps
`include "aeqc_defs.svh"

module aeqc_top #(
	parameter int DWELL_UNIT_TICKS = `AEQC_DWELL_UNIT_TICKS
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [7:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       digital_soft_reset,
	input  wire logic       cdr_lock,
	input  wire logic       cdr_error,
	input  wire logic       encoding_error,
	input  wire logic       parity_error,
	output aeqc_pkg::aeqc_gain_t gain_code
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [7:0] equalizer_error_source_select;   // 0x42
	logic [7:0] equalizer_control_restart_floor; // 0xd2
	logic [7:0] equalizer_gain_range;            // 0xd5
	logic       adaption_restart_request;        // one-shot request
	logic       first_lock_done;                 // first lock consumed
	aeqc_pkg::aeqc_state_t state;                // search state
	aeqc_pkg::aeqc_state_t next_state;
	aeqc_pkg::aeqc_gain_t  next_gain;
	logic [3:0] sync_a;                          // first sync stage
	logic [3:0] sync_b;                          // second sync stage
	logic [3:0] sync_c;                          // edge history
	logic [7:0] err_cnt;                         // saturating count

	wire        wr_err_sel  = reg_wr && (reg_addr == `AEQC_OFS_ERR_SEL);
	wire        wr_ctrl     = reg_wr && (reg_addr == `AEQC_OFS_CTRL);
	wire        wr_range    = reg_wr && (reg_addr == `AEQC_OFS_RANGE);
	wire        restart_wr  = wr_ctrl && reg_wdata[`AEQC_CT_RESTART_BIT];

	// ----------------------------------------------------------------
	// field views
	// ----------------------------------------------------------------
	wire [3:0]  gain_ceiling = equalizer_gain_range[`AEQC_RG_CEIL_LSB +: 4];
	wire [3:0]  gain_floor   = equalizer_gain_range[3:0];
	wire        gain_floor_enable =
		equalizer_control_restart_floor[`AEQC_CT_FLOOR_EN_BIT];
	wire        first_lock_enable =
		equalizer_control_restart_floor[`AEQC_CT_FIRST_BIT];
	wire [2:0]  dwell_interval_select =
		equalizer_control_restart_floor[`AEQC_CT_DWELL_LSB +: 3];
	wire        err_check_en =
		equalizer_error_source_select[`AEQC_ES_CHK_BIT];
	wire [3:0]  error_count_limit =
		equalizer_error_source_select[`AEQC_ES_LIM_LSB +: 4];
	wire [2:0]  err_src_en   = equalizer_error_source_select[2:0];

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// bit 0 lock, 1 clock recovery, 2 encoding, 3 parity
	wire [3:0]  raw_in = {parity_error, encoding_error, cdr_error, cdr_lock};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			// two flops before any logic, third only for edges
			always_ff @(posedge clk) begin
				if (reset) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
					sync_c[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
					sync_c[gi] <= sync_b[gi];
				end
			end
		end
	endgenerate

	wire        lock_s    = sync_b[0];
	wire        lock_rise = sync_b[0] && !sync_c[0];
	// an error is counted once per rising edge of its flag
	wire [2:0]  err_rise  = sync_b[3:1] & ~sync_c[3:1] & err_src_en;
	wire [1:0]  err_hits  = 2'(err_rise[0]) + 2'(err_rise[1])
	                        + 2'(err_rise[2]);

	// ----------------------------------------------------------------
	// gain stepping helpers
	// ----------------------------------------------------------------
	// next allowed gain: wrap to low limit at or beyond the ceiling
	function automatic aeqc_pkg::aeqc_gain_t step_gain(
		input aeqc_pkg::aeqc_gain_t cur,
		input logic [3:0] ceil,
		input logic [3:0] low
	);
		if (cur >= ceil) begin
			step_gain = low;
		end else if (cur < low) begin
			step_gain = low;
		end else begin
			step_gain = cur + 4'h1;
		end
	endfunction : step_gain

	wire [3:0]  low_limit  = gain_floor_enable ? gain_floor : 4'h0;
	wire [3:0]  start_gain = gain_floor;
	wire [3:0]  stepped    = step_gain(gain_code, gain_ceiling, low_limit);

	// ----------------------------------------------------------------
	// dwell timer
	// ----------------------------------------------------------------
	logic       in_window;
	logic       half_end;
	logic       dwell_end;
	logic       timer_clear;

	aeqc_timebase #(
		.DWELL_UNIT_TICKS (DWELL_UNIT_TICKS)
	) u_timebase (
		.clk       (clk),
		.reset     (reset),
		.clear     (timer_clear),
		.select    (dwell_interval_select),
		.in_window (in_window),
		.half_end  (half_end),
		.dwell_end (dwell_end)
	);

	// ----------------------------------------------------------------
	// search decisions
	// ----------------------------------------------------------------
	wire first_restart = first_lock_enable && !first_lock_done
	                     && lock_rise;
	wire restart_now   = adaption_restart_request || digital_soft_reset
	                     || first_restart;
	wire err_over      = err_check_en
	                     && (err_cnt > {4'h0, error_count_limit});
	wire settle_ok     = lock_s && !err_over;
	wire is_search     = (state == aeqc_pkg::AEQC_SEARCH);
	wire is_hold       = (state == aeqc_pkg::AEQC_HOLD);
	wire adv_dwell     = is_search && dwell_end && !settle_ok;
	wire adv_error     = half_end && err_over;
	wire adv_unlock    = is_hold && !lock_s;
	wire advance       = !restart_now
	                     && (adv_dwell || adv_error || adv_unlock);
	wire settle        = !restart_now && !advance && is_search
	                     && dwell_end && settle_ok;

	assign timer_clear = restart_now || advance || settle;

	// ----------------------------------------------------------------
	// next state and gain
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_gain  = gain_code;
		if (restart_now) begin
			next_state = aeqc_pkg::AEQC_SEARCH;
			next_gain  = start_gain;
		end else if (advance) begin
			next_state = aeqc_pkg::AEQC_SEARCH;
			next_gain  = stepped;
		end else begin
			case (state)
				aeqc_pkg::AEQC_SEARCH: begin
					if (settle) begin
						next_state = aeqc_pkg::AEQC_HOLD;
					end
				end
				aeqc_pkg::AEQC_HOLD: begin
					next_state = aeqc_pkg::AEQC_HOLD;
				end
				default: begin
					next_state = aeqc_pkg::AEQC_SEARCH;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state, gain and first-lock flag
	// ----------------------------------------------------------------
	// gain starts at reset floor value 0, the minimum
	always_ff @(posedge clk) begin
		if (reset) begin
			state           <= aeqc_pkg::AEQC_SEARCH;
			gain_code       <= 4'h0;
			first_lock_done <= 1'b0;
		end else begin
			state           <= next_state;
			gain_code       <= next_gain;
			if (lock_rise) begin
				first_lock_done <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// error accumulator
	// ----------------------------------------------------------------
	// saturates so a noisy link cannot wrap back under the limit
	always_ff @(posedge clk) begin
		if (reset || timer_clear || dwell_end) begin
			err_cnt <= 8'h0;
		end else if (in_window && err_cnt < 8'hfc) begin
			err_cnt <= err_cnt + {6'h0, err_hits};
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			equalizer_error_source_select   <= `AEQC_ERR_SEL_RST;
			equalizer_control_restart_floor <= `AEQC_CTRL_RST;
			equalizer_gain_range            <= `AEQC_RANGE_RST;
		end else begin
			if (wr_err_sel) begin
				equalizer_error_source_select <= reg_wdata;
			end
			if (wr_ctrl) begin
				// restart bit kept separately, low bits reserved
				equalizer_control_restart_floor <=
					{reg_wdata[7:4], 1'b0, reg_wdata[2], 2'b00};
			end
			if (wr_range) begin
				equalizer_gain_range <= reg_wdata;
			end
		end
	end

	// one-shot: a new write in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			adaption_restart_request <= 1'b0;
		end else if (restart_wr) begin
			adaption_restart_request <= 1'b1;
		end else begin
			adaption_restart_request <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	wire [7:0] status_view = {3'h0, is_hold, gain_code};
	wire [7:0] ctrl_view   = equalizer_control_restart_floor
	                         | {4'h0, adaption_restart_request, 3'h0};
	logic [7:0] read_mux;

	always_comb begin
		if (reg_addr == `AEQC_OFS_ERR_SEL) begin
			read_mux = equalizer_error_source_select;
		end else if (reg_addr == `AEQC_OFS_CTRL) begin
			read_mux = ctrl_view;
		end else if (reg_addr == `AEQC_OFS_STATUS) begin
			read_mux = status_view;
		end else if (reg_addr == `AEQC_OFS_RANGE) begin
			read_mux = equalizer_gain_range;
		end else begin
			read_mux = 8'h00;                               // unmapped
		end
	end

	// read data registered, valid the cycle after reg_rd
	always_ff @(posedge clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= read_mux;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_RESTART_START: assert property (
		restart_now |=> gain_code == $past(start_gain)
		                && state == aeqc_pkg::AEQC_SEARCH)
		else $error("restart did not load start gain");
	AST_RESTART_ONESHOT: assert property (
		restart_wr ##1 !restart_wr |=> !adaption_restart_request)
		else $error("restart request did not clear");
	AST_CEILING: assert property (
		advance && gain_code < gain_ceiling && gain_code >= low_limit
		|=> gain_code == $past(gain_code) + 4'h1)
		else $error("gain step wrong below ceiling");
	AST_WRAP: assert property (
		advance && gain_code >= gain_ceiling |=> gain_code == $past(low_limit))
		else $error("gain did not wrap to low limit");
	AST_FLOOR: assert property (
		advance && gain_floor_enable && !wr_range
		|=> gain_code >= gain_floor)
		else $error("gain below enabled floor");
	AST_HOLD: assert property (
		is_hold && lock_s && !restart_now && !half_end |=> $stable(gain_code))
		else $error("gain moved while locked");
	AST_UNLOCK: assert property (
		is_hold && !lock_s && !restart_now |=> gain_code == $past(stepped))
		else $error("lock loss did not advance gain");
	AST_ERR_ADV: assert property (
		half_end && err_over && !restart_now
		|=> gain_code == $past(stepped) && err_cnt == 8'h0)
		else $error("error excess did not advance gain");
	AST_READBACK: assert property (
		reg_rd && reg_addr == `AEQC_OFS_STATUS
		|=> reg_rdata[3:0] == $past(gain_code))
		else $error("status readback mismatch");

	COV_SETTLE:  cover property (settle);
	COV_WRAP:    cover property (advance && gain_code >= gain_ceiling);
	COV_FIRST:   cover property (first_restart);
	COV_ERR_ADV: cover property (adv_error && !restart_now);

endmodule : aeqc_top

// [verif/aeqc_link_model.sv]
// Purpose: far-end serializer model driving lock and error flags
// Assumes: flags change 1 ns after the rising clock edge
// Notes:   error flags pulse one cycle with a two-cycle low gap
`timescale 1ns/1ps

module aeqc_link_model (
	input  wire logic clk,            // core clock, for pacing only
	output logic      cdr_lock,       // lock level from clock recovery
	output logic      cdr_error,      // clock recovery error flag
	output logic      encoding_error, // encoding error flag
	output logic      parity_error    // parity error flag
);
	// ----------------------------------------------------------------
	// error flag vector
	// ----------------------------------------------------------------
	logic [2:0] err_v;   // one bit a source, index is source number

	assign {parity_error, encoding_error, cdr_error} = err_v;

	// quiet link at time zero
	initial begin
		cdr_lock = 1'b0;
		err_v    = 3'h0;
	end

	// lock level as the far end presents it
	task automatic set_lock(input logic v);
		@(posedge clk);
		#1;
		cdr_lock = v;
	endtask : set_lock

	// n errors; the low gap keeps every rising edge countable
	task automatic burst(input int src, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			#1;
			err_v = 3'h1 << src;
			@(posedge clk);
			#1;
			err_v = 3'h0;
			@(posedge clk);
		end
	endtask : burst

endmodule : aeqc_link_model

// [verif/adaptive_equalizer_control_test.sv]
// Purpose: self-checking bench for the equalizer gain search
// Assumes: dwell unit shortened to 4 reference ticks
// Notes:   timing checks allow one reference tick plus sync delay
`timescale 1ns/1ps
`include "aeqc_defs.svh"

module adaptive_equalizer_control_test;
	localparam int UNIT = 4;            // shortened dwell unit
	localparam int DW3  = UNIT * 8 * 8; // select 3 dwell in clocks

	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic                 clk;
	logic                 reset;
	logic [7:0]           reg_addr;
	logic                 reg_wr;
	logic [7:0]           reg_wdata;
	logic                 reg_rd;
	logic [7:0]           reg_rdata;
	logic                 digital_soft_reset;
	logic                 cdr_lock;
	logic                 cdr_error;
	logic                 encoding_error;
	logic                 parity_error;
	aeqc_pkg::aeqc_gain_t gain_code;
	logic [7:0]           q;          // last read value
	int                   n;          // cycles counted by a wait
	int                   mismatches;
	int                   checked;

	aeqc_top #(.DWELL_UNIT_TICKS(UNIT)) dut_u (
		.clk(clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .digital_soft_reset(digital_soft_reset),
		.cdr_lock(cdr_lock), .cdr_error(cdr_error),
		.encoding_error(encoding_error), .parity_error(parity_error),
		.gain_code(gain_code));

	aeqc_link_model link_u (
		.clk(clk), .cdr_lock(cdr_lock), .cdr_error(cdr_error),
		.encoding_error(encoding_error), .parity_error(parity_error));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string m);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int v, input int lo, input int hi,
			input string m);
		checked++;
		if (v < lo || v > hi) begin
			mismatches++;
			$display("[FAIL] %0t %s took %0d cycles", $time, m, v);
		end
	endtask : chk_rng

	// one register access; a read leaves its data in q
	task automatic reg_op(input logic w, input logic [7:0] a,
			input logic [7:0] d, output logic [7:0] r);
		@(posedge clk);
		#1;
		reg_wr    = w;
		reg_rd    = !w;
		reg_addr  = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		r      = reg_rdata;
	endtask : reg_op

	// bounded wait for the next gain step
	task automatic wait_chg(input int lim, output int c);
		aeqc_pkg::aeqc_gain_t g;
		g = gain_code;
		c = 0;
		while (gain_code === g && c < lim) begin
			@(posedge clk);
			#1;
			c++;
		end
		if (c >= lim) begin
			mismatches++;
			$display("[FAIL] %0t gain step wait ran out", $time);
			finish_test();
		end
	endtask : wait_chg

	task automatic do_reset();
		@(posedge clk);
		#1;
		reset = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		reset = 1'b0;
	endtask : do_reset

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		reg_op(0, `AEQC_OFS_ERR_SEL, 8'h00, q);
		chk(q, 8'h1f, "error select reset");
		reg_op(0, `AEQC_OFS_CTRL, 8'h00, q);
		chk(q, 8'h70, "control reset");
		// 2.62 ms over 40 ns is 65500 reference ticks
		chk_rng(`AEQC_DWELL_UNIT_TICKS * 8, 65492, 65508, "dwell");
		reg_op(0, `AEQC_OFS_RANGE, 8'h00, q);
		chk(q, 8'hf0, "range reset");
		reg_op(1, `AEQC_OFS_STATUS, 8'hff, q);
		reg_op(0, `AEQC_OFS_STATUS, 8'h00, q);
		chk(q, 8'h00, "status after reset");
		reg_op(1, 8'h10, 8'hff, q);
		reg_op(0, 8'h10, 8'h00, q);
		chk(q, 8'h00, "unmapped read");
		$display("test regs done");
	endtask : t_regs

	task automatic t_step();
		do_reset();
		wait_chg(DW3 + 20, n);
		chk(gain_code, 8'h01, "first step");
		wait_chg(DW3 + 20, n);
		chk_rng(n, DW3 - 10, DW3 + 10, "dwell");
		chk(gain_code, 8'h02, "second step");
		$display("test step done");
	endtask : t_step

	// ceiling 7 floor 1 without and with the floor limit
	task automatic t_wrap();
		int g;
		reg_op(1, `AEQC_OFS_RANGE, 8'h71, q);
		for (int fe = 0; fe < 2; fe++) begin
			reg_op(1, `AEQC_OFS_CTRL, 8'h08 | (fe << 2), q);
			@(posedge clk);
			#1;
			g = 1;
			chk(gain_code, 8'h01, "restart start");
			for (int i = 0; i < 9; i++) begin
				wait_chg(60, n);
				g = (g >= 7) ? fe : g + 1;
				chk(gain_code, g, "wrap step");
				chk_rng(n, 24, 40, "short dwell");
			end
		end
		$display("test wrap done");
	endtask : t_wrap

	task automatic t_restart();
		reg_op(1, `AEQC_OFS_RANGE, 8'hf5, q);
		@(posedge clk);
		#1;
		reg_wr    = 1'b1;
		reg_addr  = `AEQC_OFS_CTRL;
		reg_wdata = 8'h08;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		chk(reg_rdata, 8'h08, "restart pending");
		@(posedge clk);
		#1;
		chk(gain_code, 8'h05, "restart gain");
		reg_op(0, `AEQC_OFS_CTRL, 8'h00, q);
		chk(q, 8'h00, "restart cleared");
		wait_chg(60, n);
		chk(gain_code, 8'h06, "step after restart");
		digital_soft_reset = 1'b1;
		@(posedge clk);
		#1;
		digital_soft_reset = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk(gain_code, 8'h05, "soft reset gain");
		$display("test restart done");
	endtask : t_restart

	task automatic t_lock();
		do_reset();
		reg_op(1, `AEQC_OFS_RANGE, 8'hf3, q);
		for (int i = 0; i < 8 && gain_code !== 4'h5; i++)
			wait_chg(DW3 + 20, n);
		chk(gain_code, 8'h05, "search reached 5");
		link_u.set_lock(1'b1);
		wait_chg(20, n);
		chk(gain_code, 8'h03, "first lock restart");
		repeat (3 * DW3) @(posedge clk);
		#1;
		chk(gain_code, 8'h03, "held on lock");
		reg_op(0, `AEQC_OFS_STATUS, 8'h00, q);
		chk(q, 8'h13, "settled status");
		link_u.set_lock(1'b0);
		wait_chg(10, n);
		chk(gain_code, 8'h04, "lock loss step");
		do_reset();
		reg_op(1, `AEQC_OFS_CTRL, 8'h60, q);
		for (int i = 0; i < 4 && gain_code !== 4'h2; i++)
			wait_chg(DW3 + 20, n);
		chk(gain_code, 8'h02, "search reached 2");
		link_u.set_lock(1'b1);
		repeat (3 * DW3) @(posedge clk);
		#1;
		chk(gain_code, 8'h02, "no first lock restart");
		link_u.set_lock(1'b0);
		$display("test lock done");
	endtask : t_lock

	// select, source, count, early step expected
	task automatic t_err();
		logic [7:0] es[8] = '{8'h1f, 8'h1f, 8'h1f, 8'h1e,
			8'h17, 8'h2f, 8'h2f, 8'h1f};
		int src[8] = '{0, 1, 2, 0, 1, 2, 2, 0};
		int cnt[8] = '{2, 2, 2, 3, 3, 2, 3, 2};
		int ex[8]  = '{1, 1, 1, 0, 0, 0, 1, 0};
		do_reset();
		for (int i = 0; i < 8; i++) begin
			reg_op(1, `AEQC_OFS_ERR_SEL, es[i], q);
			wait_chg(DW3 + 20, n);
			fork
				begin
					if (i == 7)
						repeat (DW3 / 2 + 16) @(posedge clk);
					link_u.burst(src[i], cnt[i]);
				end
				wait_chg(DW3 + 20, n);
			join
			chk_rng(n, (DW3 >> ex[i]) - 12, (DW3 >> ex[i]) + 12,
				"error step");
		end
		$display("test errors done");
	endtask : t_err

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		mismatches         = 0;
		checked            = 0;
		reset              = 1'b1;
		reg_addr           = 8'h00;
		reg_wr             = 1'b0;
		reg_wdata          = 8'h00;
		reg_rd             = 1'b0;
		digital_soft_reset = 1'b0;
		repeat (20) @(posedge clk);
		#1;
		reset = 1'b0;
		t_regs();
		t_step();
		t_wrap();
		t_restart();
		t_lock();
		t_err();
		finish_test();
	end

endmodule : adaptive_equalizer_control_test
